// file: rtl/store_arith_regs.svh
// Field positions, operation codes and constants of the store/arith block
`ifndef STORE_ARITH_REGS_SVH
`define STORE_ARITH_REGS_SVH

// Instruction word fields
`define F_OPC_HI 23
`define F_OPC_LO 18
`define F_MODE 17
`define F_DES_HI 16
`define F_DES_LO 15
`define F_ADDR_HI 14
`define F_ADDR_LO 0

// Partial word store boundaries
`define W_TOP 23
`define LOW15_TOP 14
`define LOW17_TOP 16
`define CHAR_TOP 5

// Operation group of the stores (octal 4x)
`define OPC_GRP_HI 5
`define OPC_GRP_LO 3
`define OPC_GRP_STORE 3'h4

// Operation codes (octal 40..47, 30..34, 50, 51, 56, 57, 60..63)
`define OP_STORE_PRIMARY 6'h20
`define OP_STORE_SECONDARY 6'h21
`define OP_STORE_CHAR_PRIMARY 6'h22
`define OP_STORE_CHAR_SECONDARY 6'h23
`define OP_STORE_LOW15 6'h24
`define OP_STORE_PAIR 6'h25
`define OP_STORE_LOW17 6'h26
`define OP_STORE_INDEX 6'h27
`define OP_ADD_PRIMARY 6'h18
`define OP_SUBTRACT_PRIMARY 6'h19
`define OP_ADD_PAIR 6'h1a
`define OP_SUBTRACT_PAIR 6'h1b
`define OP_REPLACE_ADD 6'h1c
`define OP_MULTIPLY_PRIMARY 6'h28
`define OP_DIVIDE_PRIMARY 6'h29
`define OP_MULTIPLY_PAIR 6'h2e
`define OP_DIVIDE_PAIR 6'h2f
`define OP_FLOAT_ADD 6'h30
`define OP_FLOAT_SUBTRACT 6'h31
`define OP_FLOAT_MULTIPLY 6'h32
`define OP_FLOAT_DIVIDE 6'h33

// Register load selectors
`define SEL_A 3'h0
`define SEL_Q 3'h1
`define SEL_B1 3'h2
`define SEL_B2 3'h3
`define SEL_B3 3'h4

// Index designators
`define DES_NONE 2'h0
`define DES_ONE 2'h1
`define DES_TWO 2'h2

// Constants
`define ADDR_ONE 15'h0001
`define ADDR_ZERO 15'h0000
`define ADDR_TOP 15'h7fff
`define CHAR_MASK 24'h00003f
`define CHAR_SHIFT0 5'h12
`define CHAR_SHIFT1 5'h0c
`define CHAR_SHIFT2 5'h06
`define CHAR_SHIFT3 5'h00

`endif

// file: rtl/store_arith_pkg.sv
// Types shared by the store/arith execution datapath
package store_arith_pkg;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_INDIR = 6'h02,
    S_RD1 = 6'h04,
    S_RD2 = 6'h08,
    S_WR1 = 6'h10,
    S_WR2 = 6'h20
  } seq_e;

  typedef struct packed {
    logic req;
    logic we;
    logic [14:0] addr;
    logic [23:0] wdata;
  } mem_cmd_s;

  typedef struct packed {
    logic [23:0] a;
    logic [23:0] q;
    logic [14:0] b1;
    logic [14:0] b2;
    logic [14:0] b3;
  } regs_s;

  typedef struct packed {
    seq_e st;
    logic [5:0] opc;
    logic [1:0] desig;
    logic [14:0] addr;
    logic [1:0] csel;
    logic [23:0] hi;
    regs_s r;
    mem_cmd_s mem;
    logic done;
    logic bad;
  } state_s;

endpackage

// file: rtl/ones_add.sv
// One's-complement adder/subtractor with end-around carry
`timescale 1ns/1ns
`default_nettype none
module ones_add #(
  parameter int W = 24
) (
  // Operands
  input wire logic [W-1:0] x,
  input wire logic [W-1:0] y,
  input wire logic sub,
  // Result
  output logic [W-1:0] sum
);
  logic [W-1:0] yy;
  logic [W:0] raw;

  // Subtraction adds the complement, as one's-complement hardware does
  assign yy = sub ? ~y : y;
  assign raw = {1'b0, x} + {1'b0, yy};
  assign sum = raw[W-1:0] + {{(W-1){1'b0}}, raw[W]};
endmodule
`default_nettype wire

// file: rtl/store_arith_execute.sv
// Store and fixed-point arithmetic execution datapath
`timescale 1ns/1ns
`default_nettype none
`include "store_arith_regs.svh"

// What this block does
// - Decode opcode, mode, designator, address; index it
// - Store primary word, primary unchanged
// - Store secondary word, secondary unchanged
// - Store primary low character, rest preserved
// - Store secondary low character, rest preserved
// - Character address offset by sign-extended index
// - Character stores never resolve indirect words
// - Opcode 44 replaces low 15 word bits
// - Opcode 45 stores primary then secondary
// - Pair next address uses one's-complement add
// - Opcode 46 replaces low 17 word bits
// - Store index into unindexed address low bits
// - Index designator zero stores zero bits
// - Index store ignores indexing in indirect words
// - Decode the arithmetic operation codes
// - Arithmetic honours indexing and indirect addressing
// - Add memory word to primary
// - Subtract memory word from primary
// - Add 48-bit pair operand to pair
// - Subtract 48-bit pair operand from pair
// - Replace-add writes sum back, primary unchanged
// - Multiply primary by memory word
// - Product high half secondary, low primary
module store_arith_execute (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Instruction from decode
  input wire logic instr_valid,
  input wire logic [23:0] instr,
  output logic instr_ready,
  output logic done,
  output logic unsupported,
  // Register preload from the processor
  input wire logic reg_load,
  input wire logic [2:0] reg_load_sel,
  input wire logic [23:0] reg_load_data,
  output store_arith_pkg::regs_s regs,
  // Core storage
  output store_arith_pkg::mem_cmd_s mem_cmd,
  input wire logic [23:0] mem_rdata,
  input wire logic mem_ack
);
  store_arith_pkg::state_s cur, nxt;

  logic [14:0] ea_m, ea_b, ea_sum, pair_next;
  logic [16:0] chr_off, chr_sum;
  logic [23:0] opnd_hi, sum24, wr_data, mul_a, mul_b;
  logic [47:0] sum48, prod, mul_res;
  logic sub24, sub48, launch, mul_neg;
  logic [14:0] launch_addr;
  logic [5:0] launch_opc;
  logic [1:0] launch_des;

  function automatic logic [14:0] idx_of(input logic [1:0] b,
                                         input store_arith_pkg::regs_s r);
    case (b)
      2'h1: idx_of = r.b1;
      2'h2: idx_of = r.b2;
      2'h3: idx_of = r.b3;
      default: idx_of = `ADDR_ZERO;
    endcase
  endfunction

  function automatic logic [23:0] char_merge(input logic [23:0] w,
                                             input logic [1:0] sel,
                                             input logic [5:0] c);
    logic [4:0] sh;
    sh = `CHAR_SHIFT3;
    case (sel)
      2'h0: sh = `CHAR_SHIFT0;
      2'h1: sh = `CHAR_SHIFT1;
      2'h2: sh = `CHAR_SHIFT2;
      default: sh = `CHAR_SHIFT3;
    endcase
    char_merge = (w & ~(`CHAR_MASK << sh)) | ({18'h0, c} << sh);
  endfunction

  // ********************************************************
  // Address and arithmetic adders
  // ********************************************************
  ones_add #(.W(15)) u_ea (
    .x(ea_m), .y(ea_b), .sub(1'b0), .sum(ea_sum)
  );
  ones_add #(.W(15)) u_pair (
    .x(cur.addr), .y(`ADDR_ONE), .sub(1'b0), .sum(pair_next)
  );
  ones_add #(.W(17)) u_chr (
    .x({2'h0, instr[`F_ADDR_HI:`F_ADDR_LO]}), .y(chr_off), .sub(1'b0),
    .sum(chr_sum)
  );
  ones_add #(.W(24)) u_acc24 (
    .x(cur.r.a), .y(opnd_hi), .sub(sub24), .sum(sum24)
  );
  ones_add #(.W(48)) u_acc48 (
    .x({cur.r.a, cur.r.q}), .y({cur.hi, mem_rdata}), .sub(sub48),
    .sum(sum48)
  );

  always_comb begin
    // Indexing is applied from the instruction, or from an indirect
    // word; the index store never indexes at all
    if (cur.st == store_arith_pkg::S_INDIR) begin
      ea_m = mem_rdata[`F_ADDR_HI:`F_ADDR_LO];
      ea_b = (cur.opc == `OP_STORE_INDEX) ? `ADDR_ZERO :
             idx_of(mem_rdata[`F_DES_HI:`F_DES_LO], cur.r);
    end else begin
      ea_m = instr[`F_ADDR_HI:`F_ADDR_LO];
      ea_b = (instr[`F_OPC_HI:`F_OPC_LO] == `OP_STORE_INDEX) ? `ADDR_ZERO :
             idx_of(instr[`F_DES_HI:`F_DES_LO], cur.r);
    end
  end

  // Character offset: any nonzero designator picks B2 for the primary store,
  // B1 for the secondary store, sign-extended to the character width
  always_comb begin
    chr_off = 17'h0;
    if (instr[`F_DES_HI:`F_DES_LO] != `DES_NONE) begin
      if (instr[`F_OPC_HI:`F_OPC_LO] == `OP_STORE_CHAR_PRIMARY)
        chr_off = {{2{cur.r.b2[`LOW15_TOP]}}, cur.r.b2};
      else
        chr_off = {{2{cur.r.b1[`LOW15_TOP]}}, cur.r.b1};
    end
  end

  // Operand from storage is live in the read cycle, held afterwards
  assign opnd_hi = (cur.st == store_arith_pkg::S_RD1) ? mem_rdata : cur.hi;
  assign sub24 = (cur.opc == `OP_SUBTRACT_PRIMARY);
  assign sub48 = (cur.opc == `OP_SUBTRACT_PAIR);

  // Sign-magnitude multiply, complemented back for a negative product
  assign mul_a = cur.r.a[`W_TOP] ? ~cur.r.a : cur.r.a;
  assign mul_b = opnd_hi[`W_TOP] ? ~opnd_hi : opnd_hi;
  assign mul_neg = cur.r.a[`W_TOP] ^ opnd_hi[`W_TOP];
  assign prod = {24'h0, mul_a} * {24'h0, mul_b};
  assign mul_res = mul_neg ? ~prod : prod;

  // ********************************************************
  // Store data for the first write of each instruction
  // ********************************************************
  // Merges take the word as it is read: hi only lands at that edge
  always_comb begin
    case (cur.opc)
      `OP_STORE_PRIMARY: wr_data = cur.r.a;
      `OP_STORE_SECONDARY: wr_data = cur.r.q;
      `OP_STORE_PAIR: wr_data = cur.r.a;
      `OP_STORE_CHAR_PRIMARY:
        wr_data = char_merge(opnd_hi, cur.csel,
                             cur.r.a[`CHAR_TOP:0]);
      `OP_STORE_CHAR_SECONDARY:
        wr_data = char_merge(opnd_hi, cur.csel,
                             cur.r.q[`CHAR_TOP:0]);
      `OP_STORE_LOW15:
        wr_data = {opnd_hi[`W_TOP:`LOW15_TOP+1],
                   cur.r.a[`LOW15_TOP:0]};
      `OP_STORE_LOW17:
        wr_data = {opnd_hi[`W_TOP:`LOW17_TOP+1],
                   cur.r.a[`LOW17_TOP:0]};
      `OP_STORE_INDEX:
        wr_data = {opnd_hi[`W_TOP:`LOW15_TOP+1],
                   idx_of(cur.desig, cur.r)};
      `OP_REPLACE_ADD: wr_data = sum24;
      default: wr_data = cur.r.a;
    endcase
  end

  // ********************************************************
  // Sequencer
  // ********************************************************
  always_comb begin
    nxt = cur;
    nxt.done = 1'b0;
    nxt.bad = 1'b0;
    launch = 1'b0;
    launch_addr = ea_sum;
    launch_opc = cur.opc;
    launch_des = cur.desig;
    case (cur.st)
      store_arith_pkg::S_IDLE: begin
        if (instr_valid) begin
          nxt.opc = instr[`F_OPC_HI:`F_OPC_LO];
          nxt.desig = instr[`F_DES_HI:`F_DES_LO];
          launch_opc = instr[`F_OPC_HI:`F_OPC_LO];
          case (instr[`F_OPC_HI:`F_OPC_LO])
            `OP_STORE_CHAR_PRIMARY, `OP_STORE_CHAR_SECONDARY: begin
              // Mode bit is not looked at: no indirect resolution
              nxt.addr = chr_sum[16:2];
              nxt.csel = chr_sum[1:0];
              nxt.st = store_arith_pkg::S_RD1;
              nxt.mem = '{1'b1, 1'b0, chr_sum[16:2], 24'h0};
            end
            `OP_STORE_PRIMARY, `OP_STORE_SECONDARY, `OP_STORE_LOW15,
            `OP_STORE_PAIR, `OP_STORE_LOW17, `OP_STORE_INDEX,
            `OP_ADD_PRIMARY, `OP_SUBTRACT_PRIMARY, `OP_ADD_PAIR,
            `OP_SUBTRACT_PAIR, `OP_REPLACE_ADD,
            `OP_MULTIPLY_PRIMARY: begin
              if (instr[`F_MODE]) begin
                nxt.st = store_arith_pkg::S_INDIR;
                nxt.mem = '{1'b1, 1'b0, ea_sum, 24'h0};
              end else begin
                launch = 1'b1;
              end
            end
            default: begin
              // Divide and floating point are handled elsewhere
              nxt.done = 1'b1;
              nxt.bad = 1'b1;
            end
          endcase
        end else if (reg_load) begin
          case (reg_load_sel)
            `SEL_A: nxt.r.a = reg_load_data;
            `SEL_Q: nxt.r.q = reg_load_data;
            `SEL_B1: nxt.r.b1 = reg_load_data[`LOW15_TOP:0];
            `SEL_B2: nxt.r.b2 = reg_load_data[`LOW15_TOP:0];
            `SEL_B3: nxt.r.b3 = reg_load_data[`LOW15_TOP:0];
            default: nxt.r = cur.r;
          endcase
        end
      end
      store_arith_pkg::S_INDIR: begin
        if (mem_ack) begin
          if (mem_rdata[`F_MODE]) begin
            nxt.mem.addr = ea_sum;
          end else begin
            launch = 1'b1;
          end
        end
      end
      store_arith_pkg::S_RD1: begin
        if (mem_ack) begin
          nxt.hi = mem_rdata;
          case (cur.opc)
            `OP_ADD_PRIMARY, `OP_SUBTRACT_PRIMARY: begin
              nxt.r.a = sum24;
              nxt.mem.req = 1'b0;
              nxt.st = store_arith_pkg::S_IDLE;
              nxt.done = 1'b1;
            end
            `OP_MULTIPLY_PRIMARY: begin
              nxt.r.q = mul_res[47:24];
              nxt.r.a = mul_res[23:0];
              nxt.mem.req = 1'b0;
              nxt.st = store_arith_pkg::S_IDLE;
              nxt.done = 1'b1;
            end
            `OP_ADD_PAIR, `OP_SUBTRACT_PAIR: begin
              nxt.addr = pair_next;
              nxt.mem.addr = pair_next;
              nxt.st = store_arith_pkg::S_RD2;
            end
            default: begin
              nxt.st = store_arith_pkg::S_WR1;
              nxt.mem.we = 1'b1;
              nxt.mem.wdata = wr_data;
            end
          endcase
        end
      end
      store_arith_pkg::S_RD2: begin
        if (mem_ack) begin
          {nxt.r.a, nxt.r.q} = sum48;
          nxt.mem.req = 1'b0;
          nxt.st = store_arith_pkg::S_IDLE;
          nxt.done = 1'b1;
        end
      end
      store_arith_pkg::S_WR1: begin
        if (mem_ack) begin
          if (cur.opc == `OP_STORE_PAIR) begin
            nxt.addr = pair_next;
            nxt.mem.addr = pair_next;
            nxt.mem.wdata = cur.r.q;
            nxt.st = store_arith_pkg::S_WR2;
          end else begin
            nxt.mem.req = 1'b0;
            nxt.mem.we = 1'b0;
            nxt.st = store_arith_pkg::S_IDLE;
            nxt.done = 1'b1;
          end
        end
      end
      store_arith_pkg::S_WR2: begin
        if (mem_ack) begin
          nxt.mem.req = 1'b0;
          nxt.mem.we = 1'b0;
          nxt.st = store_arith_pkg::S_IDLE;
          nxt.done = 1'b1;
        end
      end
      default: nxt.st = store_arith_pkg::S_IDLE;
    endcase

    // Full-word stores write at once; everything else reads first
    if (launch) begin
      nxt.addr = launch_addr;
      if (launch_opc == `OP_STORE_PRIMARY ||
          launch_opc == `OP_STORE_PAIR) begin
        nxt.st = store_arith_pkg::S_WR1;
        nxt.mem = '{1'b1, 1'b1, launch_addr, cur.r.a};
      end else if (launch_opc == `OP_STORE_SECONDARY) begin
        nxt.st = store_arith_pkg::S_WR1;
        nxt.mem = '{1'b1, 1'b1, launch_addr, cur.r.q};
      end else begin
        nxt.st = store_arith_pkg::S_RD1;
        nxt.mem = '{1'b1, 1'b0, launch_addr, 24'h0};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '{st: store_arith_pkg::S_IDLE, default: '0};
    end else begin
      cur <= nxt;
    end
  end

  assign instr_ready = (cur.st == store_arith_pkg::S_IDLE);
  assign done = cur.done;
  assign unsupported = cur.bad;
  assign regs = cur.r;
  assign mem_cmd = cur.mem;

  // ********************************************************
  // Checks
  // ********************************************************
  property p_store_primary_data;
    @(posedge ref_clk) disable iff (!rst_n)
    (cur.mem.req && cur.mem.we && cur.opc == `OP_STORE_PRIMARY)
      |-> cur.mem.wdata == cur.r.a;
  endproperty
  a_store_primary_data: assert property (p_store_primary_data)
    else $error("primary store data differs from A");

  property p_store_secondary_data;
    @(posedge ref_clk) disable iff (!rst_n)
    (cur.mem.req && cur.mem.we && cur.opc == `OP_STORE_SECONDARY)
      |-> cur.mem.wdata == cur.r.q;
  endproperty
  a_store_secondary_data: assert property (p_store_secondary_data)
    else $error("secondary store data differs from Q");

  property p_char_keep;
    @(posedge ref_clk) disable iff (!rst_n)
    (cur.st == store_arith_pkg::S_WR1 &&
     (cur.opc == `OP_STORE_CHAR_PRIMARY ||
      cur.opc == `OP_STORE_CHAR_SECONDARY))
      |-> ((cur.mem.wdata ^ cur.hi) &
           ~(`CHAR_MASK << (6 * (2'h3 - cur.csel)))) == 24'h0 &&
          cur.mem.wdata[6 * (2'h3 - cur.csel) +: 6] ==
          (cur.opc == `OP_STORE_CHAR_PRIMARY ? cur.r.a[5:0] :
           cur.r.q[5:0]);
  endproperty
  a_char_keep: assert property (p_char_keep)
    else $error("character store disturbs other characters");

  property p_low15;
    @(posedge ref_clk) disable iff (!rst_n)
    (cur.st == store_arith_pkg::S_WR1 && cur.opc == `OP_STORE_LOW15)
      |-> cur.mem.wdata[23:15] == cur.hi[23:15] &&
          cur.mem.wdata[14:0] == cur.r.a[14:0];
  endproperty
  a_low15: assert property (p_low15)
    else $error("low-15 store merged wrongly");

  property p_low17;
    @(posedge ref_clk) disable iff (!rst_n)
    (cur.st == store_arith_pkg::S_WR1 && cur.opc == `OP_STORE_LOW17)
      |-> cur.mem.wdata[23:17] == cur.hi[23:17] &&
          cur.mem.wdata[16:0] == cur.r.a[16:0];
  endproperty
  a_low17: assert property (p_low17)
    else $error("low-17 store merged wrongly");

  property p_index_zero;
    @(posedge ref_clk) disable iff (!rst_n)
    (cur.st == store_arith_pkg::S_WR1 && cur.opc == `OP_STORE_INDEX &&
     cur.desig == `DES_NONE) |-> cur.mem.wdata[14:0] == 15'h0;
  endproperty
  a_index_zero: assert property (p_index_zero)
    else $error("index store with designator zero not zero");

  // Top of storage wraps to one, as one's-complement +1 does
  property p_pair_addr;
    @(posedge ref_clk) disable iff (!rst_n)
    (cur.st == store_arith_pkg::S_WR1 && cur.opc == `OP_STORE_PAIR &&
     mem_ack) |=> cur.mem.addr == (($past(cur.mem.addr) == `ADDR_TOP) ?
     `ADDR_ONE : $past(cur.mem.addr) + `ADDR_ONE) &&
     cur.mem.wdata == cur.r.q;
  endproperty
  a_pair_addr: assert property (p_pair_addr)
    else $error("second pair write wrong");

  property p_replace_add;
    @(posedge ref_clk) disable iff (!rst_n)
    (cur.st == store_arith_pkg::S_WR1 && cur.opc == `OP_REPLACE_ADD)
      |-> cur.mem.wdata == sum24 && $stable(cur.r.a);
  endproperty
  a_replace_add: assert property (p_replace_add)
    else $error("replace-add write data wrong");

  property p_store_keeps_a;
    @(posedge ref_clk) disable iff (!rst_n)
    (cur.st != store_arith_pkg::S_IDLE &&
     cur.opc[`OPC_GRP_HI:`OPC_GRP_LO] == `OPC_GRP_STORE)
      |=> $stable(cur.r.a) && $stable(cur.r.q);
  endproperty
  a_store_keeps_a: assert property (p_store_keeps_a)
    else $error("store changed an accumulator");

  property p_req_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    (cur.mem.req && !mem_ack) |=> cur.mem.req && $stable(cur.mem.addr);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("storage request dropped before acknowledge");
endmodule
`default_nettype wire

// file: tb/core_store_model.sv
// Behavioural word-addressed core storage for the execute block
`timescale 1ns/1ns
`default_nettype none
module core_store_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Command side
  input wire store_arith_pkg::mem_cmd_s mem_cmd,
  input wire logic slow,
  output logic [23:0] mem_rdata,
  output logic mem_ack
);
  logic [23:0] mem [0:32767];
  int wait_n;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 24'h000000;
    wait_n = 0;
  end
  // ****
  // Answer
  // ****
  // Idle data lines toggle so a stale word is never mistaken for a read
  always @(negedge ref_clk) begin
    if (mem_ack || !mem_cmd.req || !rst_n) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_n <= slow ? 2 : 0;
    end else if (wait_n != 0) begin
      wait_n <= wait_n - 1;
    end else begin
      mem_ack <= 1'b1;
      mem_rdata <= mem_cmd.we ? ~mem_rdata : mem[mem_cmd.addr];
    end
  end
  always @(posedge ref_clk) begin
    if (mem_ack && mem_cmd.req && mem_cmd.we) begin
      mem[mem_cmd.addr] <= mem_cmd.wdata;
    end
  end
endmodule
`default_nettype wire

// file: tb/store_arith_execute_tb.sv
// Self-checking bench for the store and arithmetic execute block
`timescale 1ns/1ns
`default_nettype none
module store_arith_execute_tb;
  logic ref_clk, rst_n, instr_valid, instr_ready, done, unsupported;
  logic reg_load, mem_ack, slow;
  logic [23:0] instr, reg_load_data, mem_rdata;
  logic [2:0] reg_load_sel;
  store_arith_pkg::regs_s regs, exp_r;
  store_arith_pkg::mem_cmd_s mem_cmd;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 32'h7f81;
  logic [5:0] ops [21] = '{6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25,
    6'h26, 6'h27, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h28, 6'h29,
    6'h2e, 6'h2f, 6'h30, 6'h31, 6'h32, 6'h33};

  store_arith_execute u_store_arith_execute (.ref_clk(ref_clk),
    .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .done(done), .unsupported(unsupported),
    .reg_load(reg_load), .reg_load_sel(reg_load_sel),
    .reg_load_data(reg_load_data), .regs(regs), .mem_cmd(mem_cmd),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  core_store_model u_core_store_model (.ref_clk(ref_clk), .rst_n(rst_n),
    .mem_cmd(mem_cmd), .slow(slow), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ****
  // Helpers
  // ****
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [47:0] e,
                     input logic [47:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  // One's complement sum of n-bit values with end-around carry
  function automatic logic [47:0] oc(input logic [47:0] x,
                                     input logic [47:0] y, input int n);
    logic [48:0] s, msk;
    msk = (49'h1 << n) - 49'h1;
    s = {1'b0, x} + {1'b0, y};
    s = (s & msk) + (s >> n);
    return s[47:0] & msk[47:0];
  endfunction
  task automatic set_reg(input logic [2:0] sel, input logic [23:0] d);
    @(negedge ref_clk);
    reg_load = 1'b1;
    reg_load_sel = sel;
    reg_load_data = d;
    @(negedge ref_clk);
    reg_load = 1'b0;
  endtask
  task automatic do_op(input logic [5:0] op, input logic [1:0] des,
                       input logic [14:0] m, input logic ind);
    logic [14:0] x, ea, fa, fa1, x2;
    logic [16:0] r;
    logic [23:0] w0, w1, e0, e1, nw, src;
    logic [47:0] p;
    logic is_chr;
    int sh;
    is_chr = (op == 6'h22) || (op == 6'h23);
    exp_r.a = $random(seed);
    exp_r.q = $random(seed);
    exp_r.b1 = 15'($random(seed)) & 15'h07ff;
    exp_r.b2 = 15'($random(seed)) & 15'h07ff;
    exp_r.b3 = 15'($random(seed)) & 15'h07ff;
    if (is_chr && ($random(seed) & 1)) begin
      exp_r.b1 = ~exp_r.b1;
      exp_r.b2 = ~exp_r.b2;
    end
    set_reg(3'h0, exp_r.a);
    set_reg(3'h1, exp_r.q);
    set_reg(3'h2, {9'h000, exp_r.b1});
    set_reg(3'h3, {9'h000, exp_r.b2});
    set_reg(3'h4, {9'h000, exp_r.b3});
    x = des == 2'h1 ? exp_r.b1 : des == 2'h2 ? exp_r.b2 :
        des == 2'h3 ? exp_r.b3 : 15'h0000;
    ea = op == 6'h27 ? m : 15'(oc({33'h0, m}, {33'h0, x}, 15));
    fa = ea;
    if (is_chr) begin
      src = op == 6'h22 ? {9'h000, exp_r.b2} : {9'h000, exp_r.b1};
      r = {2'b00, m};
      if (des != 2'h0) begin
        r = 17'(oc({31'h0, r}, {31'h0, {2{src[14]}}, src[14:0]}, 17));
      end
      fa = r[16:2];
      sh = (3 - int'(r[1:0])) * 6;
    end else if (ind) begin
      // Odd m adds a second indirect level through x2
      fa = ea ^ 15'h2000;
      x2 = m[0] ? ea ^ 15'h4000 : ea;
      u_core_store_model.mem[ea] = {6'h00, 1'b1,
        op == 6'h27 ? 2'b11 : 2'b00, x2};
      u_core_store_model.mem[x2] = {7'h00, op == 6'h27 ? 2'b11 : 2'b00, fa};
    end
    fa1 = 15'(oc({33'h0, fa}, 48'h1, 15));
    w0 = $random(seed);
    w1 = $random(seed);
    u_core_store_model.mem[fa] = w0;
    u_core_store_model.mem[fa1] = w1;
    e0 = w0;
    e1 = w1;
    nw = ~w0;
    case (op)
      6'h20: e0 = exp_r.a;
      6'h21: e0 = exp_r.q;
      6'h22, 6'h23: begin
        src = op == 6'h22 ? exp_r.a : exp_r.q;
        e0 = (w0 & ~(24'h00003f << sh)) | ({18'h0, src[5:0]} << sh);
      end
      6'h24: e0 = {w0[23:15], exp_r.a[14:0]};
      6'h25: begin
        e0 = exp_r.a;
        e1 = exp_r.q;
      end
      6'h26: e0 = {w0[23:17], exp_r.a[16:0]};
      6'h27: e0 = {w0[23:15], x};
      6'h18: exp_r.a = 24'(oc({24'h0, exp_r.a}, {24'h0, w0}, 24));
      6'h19: exp_r.a = 24'(oc({24'h0, exp_r.a}, {24'h0, nw}, 24));
      6'h1a: {exp_r.a, exp_r.q} = oc({exp_r.a, exp_r.q}, {w0, w1}, 48);
      6'h1b: {exp_r.a, exp_r.q} = oc({exp_r.a, exp_r.q}, ~{w0, w1}, 48);
      6'h1c: e0 = 24'(oc({24'h0, w0}, {24'h0, exp_r.a}, 24));
      6'h28: begin
        src = exp_r.a[23] ? ~exp_r.a : exp_r.a;
        nw = w0[23] ? ~w0 : w0;
        p = src * nw;
        {exp_r.q, exp_r.a} = (exp_r.a[23] ^ w0[23]) ? ~p : p;
      end
      default: ;
    endcase
    @(negedge ref_clk);
    instr_valid = 1'b1;
    instr = {op, ind, des, m};
    @(negedge ref_clk);
    instr_valid = 1'b0;
    chk("ready", {47'h0, op > 6'h28 || op == 6'h1d},
        {47'h0, instr_ready});
    for (int k = 0; k < 60 && done !== 1'b1; k++) @(negedge ref_clk);
    chk("done", 48'h1, {47'h0, done});
    chk("unsupported", {47'h0, op > 6'h28 || op == 6'h1d},
        {47'h0, unsupported});
    chk("word", {24'h0, e0}, {24'h0, u_core_store_model.mem[fa]});
    chk("next", {24'h0, e1}, {24'h0, u_core_store_model.mem[fa1]});
    chk("a", {24'h0, exp_r.a}, {24'h0, regs.a});
    chk("q", {24'h0, exp_r.q}, {24'h0, regs.q});
    chk("b", {3'h0, exp_r.b1, exp_r.b2, exp_r.b3},
        {3'h0, regs.b1, regs.b2, regs.b3});
  endtask

  // ****
  // Sequence
  // ****
  initial begin
    logic [5:0] op;
    instr_valid = 1'b0;
    instr = 24'h000000;
    reg_load = 1'b0;
    reg_load_sel = 3'h0;
    reg_load_data = 24'h000000;
    slow = 1'b0;
    rst_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    // Pair addresses at the top of storage wrap non-consecutively
    for (int i = 0; i < 2; i++) begin
      do_op(6'h25, 2'h0, i ? 15'h7fff : 15'h7ffe, 1'b0);
      do_op(6'h1a, 2'h0, i ? 15'h7fff : 15'h7ffe, 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      do_op(6'h23, 2'h0, 15'(i), 1'b0);
    end
    do_op(6'h27, 2'h0, 15'h0123, 1'b1);
    for (int n = 0; n < 10; n++) begin
      for (int j = 0; j < 21; j++) begin
        op = ops[j];
        slow <= 1'($random(seed));
        do_op(op, 2'($random(seed)),
              (op == 6'h22 || op == 6'h23) ? 15'($random(seed)) :
              15'($random(seed)) & 15'h3fff,
              (op == 6'h22 || op == 6'h23) ? 1'b0 :
              1'($random(seed)));
      end
    end
    print_verdict();
  end
endmodule
`default_nettype wire
